// [design/pamux_cfg.svh]
// offsets, field positions, reset values and mode codes of the port a function mux
`ifndef PAMUX_CFG_SVH
`define PAMUX_CFG_SVH

// ==========================================================
// register byte offsets
`define PAMUX_OFS_FUNC_SEL 12'h000
`define PAMUX_OFS_PORT_OUT 12'h004
`define PAMUX_OFS_PORT_DIR 12'h008
`define PAMUX_OFS_PORT_PIN 12'h00C
`define PAMUX_OFS_PIN_DRIVE 12'h010

// ==========================================================
// reset values
`define PAMUX_RST_FUNC_SEL 8'h00
`define PAMUX_RST_PORT_OUT 8'h00
`define PAMUX_RST_PORT_DIR 8'h00

// ==========================================================
// function select bit positions
`define PAMUX_BIT_TMR0 0
`define PAMUX_BIT_TMR1 1
`define PAMUX_BIT_MEMOE 2
`define PAMUX_BIT_MEMCS 3
`define PAMUX_BIT_FIFOWR 4
`define PAMUX_BIT_FIFORD 5
`define PAMUX_BIT_SER0 6
`define PAMUX_BIT_SER1 7

// ==========================================================
// timer and serial mode codes
`define PAMUX_MODE_SPLIT 2'h3
`define PAMUX_MODE_SYNC 2'h0

`endif

// [design/pamux_pkg.sv]
// types of the port a function mux
package pamux_pkg;

    // ==========================================================
    // apb slave states
    typedef enum logic [1:0] {
        PAMUX_IDLE = 2'b01,
        PAMUX_ANSWER = 2'b10
    } pamux_apb_state_type;

    // ==========================================================
    // state of the overflow pulse cell
    typedef struct packed {
        logic prevSrc;
        logic pulse;
    } pamux_pulse_type;

    // ==========================================================
    // state of the top module
    typedef struct packed {
        pamux_apb_state_type apbState;
        logic [7:0] funcSel;
        logic [7:0] portOut;
        logic [7:0] portDir;
        logic [7:0] pinSample;
        logic [7:0] pinDrv;
        logic [7:0] pinOe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pamux_main_type;

endpackage

// [design/pamux_ovf_pulse.sv]
// one-cycle overflow pulse of one timer, low byte source in split mode
`timescale 1ns/1ps
`include "pamux_cfg.svh"

module pamux_ovf_pulse (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] timerMode,
    input wire logic ovfFull,
    input wire logic ovfLow,
    output logic overflowPulse
);

    pamux_pkg::pamux_pulse_type state_ff;
    pamux_pkg::pamux_pulse_type nxt_state;
    logic src;

    assign src = (timerMode == `PAMUX_MODE_SPLIT) ? ovfLow : ovfFull;

    // ==========================================================
    // edge of the selected overflow gives exactly one cycle high
    always_comb begin
        nxt_state = state_ff;
        nxt_state.prevSrc = src;
        nxt_state.pulse = src & ~state_ff.prevSrc;
        if (rst) begin
            nxt_state = '0;
        end
    end

    always_ff @(posedge mclk) begin
        state_ff <= nxt_state;
    end

    assign overflowPulse = state_ff.pulse;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_pulse_one_cycle: assert property (overflowPulse |=> !overflowPulse)
        else $error("overflow pulse longer than one cycle");

    a_split_low_byte: assert property (
        (timerMode == `PAMUX_MODE_SPLIT && ovfLow && !state_ff.prevSrc) |=> overflowPulse)
        else $error("split mode low byte overflow gave no pulse");

    a_pulse_has_cause: assert property (
        overflowPulse |-> $past(src) && !$past(state_ff.prevSrc))
        else $error("overflow pulse without overflow");

endmodule

// [design/pamux_port_a.sv]
// port a pin function mux with apb register file
//
// Notes on behaviour
// - pin0 port bit, or timer0 overflow when selected
// - timer0 pulse is one cycle per overflow
// - timer0 split mode uses low byte overflow
// - pin1 port bit, or timer1 overflow when selected
// - timer1 one-cycle pulse, low byte when split
// - pin2 port bit, or memory output enable low
// - pin3 port bit, or memory chip select low
// - pin4 port bit, or fifo write strobe low
// - pin5 port bit, or fifo read strobe low
// - pin6 port bit, or serial0 data out
// - serial0 data only in sync mode, else 1
// - pin7 port bit, or serial1 data out
// - serial1 data in mode 0, 1 otherwise
`timescale 1ns/1ps
`include "pamux_cfg.svh"

module pamux_port_a (
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer overflow events and modes
    input wire logic [1:0] timer0Mode,
    input wire logic timer0OvfFull,
    input wire logic timer0OvfLow,
    input wire logic [1:0] timer1Mode,
    input wire logic timer1OvfFull,
    input wire logic timer1OvfLow,
    // external memory and fifo strobes, active low
    input wire logic memOeN,
    input wire logic memCsN,
    input wire logic fifoWriteStrobeN,
    input wire logic fifoReadStrobeN,
    // serial ports
    input wire logic [1:0] serial0Mode,
    input wire logic serial0SyncDataOut,
    input wire logic [1:0] serial1Mode,
    input wire logic serial1SyncDataOut,
    // the eight pins
    input wire logic [7:0] firstPortBitIn,
    output logic [7:0] firstPortBitOut,
    output logic [7:0] firstPortBitOe
);

    localparam logic [4:0] HIT_FUNC = 5'h01;
    localparam logic [4:0] HIT_OUT = 5'h02;
    localparam logic [4:0] HIT_DIR = 5'h04;
    localparam logic [4:0] HIT_PIN = 5'h08;
    localparam logic [4:0] HIT_DRV = 5'h10;

    pamux_pkg::pamux_main_type state_ff;
    pamux_pkg::pamux_main_type nxt_state;

    logic timer0Pulse;
    logic timer1Pulse;
    logic serial0Val;
    logic serial1Val;
    logic [7:0] altVal;
    logic [4:0] hit;
    logic writeNow;

    // ==========================================================
    // address decode shared by read and write
    function automatic logic [4:0] pamux_decode(input logic [11:0] addr);
        logic [4:0] oneHot;
        oneHot = 5'h00;
        case (addr)
            `PAMUX_OFS_FUNC_SEL: begin
                oneHot = HIT_FUNC;
            end
            `PAMUX_OFS_PORT_OUT: begin
                oneHot = HIT_OUT;
            end
            `PAMUX_OFS_PORT_DIR: begin
                oneHot = HIT_DIR;
            end
            `PAMUX_OFS_PORT_PIN: begin
                oneHot = HIT_PIN;
            end
            `PAMUX_OFS_PIN_DRIVE: begin
                oneHot = HIT_DRV;
            end
            default: begin
                oneHot = 5'h00;
            end
        endcase
        return oneHot;
    endfunction

    // ==========================================================
    // timer overflow pulse cells
    pamux_ovf_pulse u_timer0Pulse (
        .mclk(mclk),
        .rst(rst),
        .timerMode(timer0Mode),
        .ovfFull(timer0OvfFull),
        .ovfLow(timer0OvfLow),
        .overflowPulse(timer0Pulse)
    );

    pamux_ovf_pulse u_timer1Pulse (
        .mclk(mclk),
        .rst(rst),
        .timerMode(timer1Mode),
        .ovfFull(timer1OvfFull),
        .ovfLow(timer1OvfLow),
        .overflowPulse(timer1Pulse)
    );

    // ==========================================================
    // alternate function values
    assign serial0Val = (serial0Mode == `PAMUX_MODE_SYNC) ? serial0SyncDataOut : 1'b1;
    assign serial1Val = (serial1Mode == `PAMUX_MODE_SYNC) ? serial1SyncDataOut : 1'b1;

    always_comb begin
        altVal = 8'h00;
        altVal[`PAMUX_BIT_TMR0] = timer0Pulse;
        altVal[`PAMUX_BIT_TMR1] = timer1Pulse;
        altVal[`PAMUX_BIT_MEMOE] = memOeN;
        altVal[`PAMUX_BIT_MEMCS] = memCsN;
        altVal[`PAMUX_BIT_FIFOWR] = fifoWriteStrobeN;
        altVal[`PAMUX_BIT_FIFORD] = fifoReadStrobeN;
        altVal[`PAMUX_BIT_SER0] = serial0Val;
        altVal[`PAMUX_BIT_SER1] = serial1Val;
    end

    assign hit = pamux_decode(paddr);
    assign writeNow = (state_ff.apbState == pamux_pkg::PAMUX_ANSWER) && psel && penable
        && pwrite;

    // ==========================================================
    // next state
    always_comb begin
        nxt_state = state_ff;
        nxt_state.pinSample = firstPortBitIn;
        nxt_state.pready = 1'b0;
        nxt_state.pslverr = 1'b0;

        // selected pins take the alternate function and always drive
        nxt_state.pinDrv = (state_ff.funcSel & altVal) | (~state_ff.funcSel & state_ff.portOut);
        nxt_state.pinOe = state_ff.funcSel | state_ff.portDir;

        case (state_ff.apbState)
            pamux_pkg::PAMUX_IDLE: begin
                if (psel && !penable) begin
                    nxt_state.apbState = pamux_pkg::PAMUX_ANSWER;
                    nxt_state.pready = 1'b1;
                    nxt_state.pslverr = (hit == 5'h00);
                    nxt_state.prdata = 32'h0000_0000;
                    if (!pwrite) begin
                        case (hit)
                            HIT_FUNC: begin
                                nxt_state.prdata = {24'h00_0000, state_ff.funcSel};
                            end
                            HIT_OUT: begin
                                nxt_state.prdata = {24'h00_0000, state_ff.portOut};
                            end
                            HIT_DIR: begin
                                nxt_state.prdata = {24'h00_0000, state_ff.portDir};
                            end
                            HIT_PIN: begin
                                nxt_state.prdata = {24'h00_0000, state_ff.pinSample};
                            end
                            HIT_DRV: begin
                                nxt_state.prdata = {16'h0000, state_ff.pinOe,
                                    state_ff.pinDrv};
                            end
                            default: begin
                                nxt_state.prdata = 32'h0000_0000;
                            end
                        endcase
                    end
                end
            end
            pamux_pkg::PAMUX_ANSWER: begin
                nxt_state.apbState = pamux_pkg::PAMUX_IDLE;
                if (writeNow) begin
                    case (hit)
                        HIT_FUNC: begin
                            nxt_state.funcSel = pwdata[7:0];
                        end
                        HIT_OUT: begin
                            nxt_state.portOut = pwdata[7:0];
                        end
                        HIT_DIR: begin
                            nxt_state.portDir = pwdata[7:0];
                        end
                        default: begin
                            nxt_state.funcSel = state_ff.funcSel;
                        end
                    endcase
                end
            end
            default: begin
                nxt_state.apbState = pamux_pkg::PAMUX_IDLE;
            end
        endcase

        if (rst) begin
            nxt_state.apbState = pamux_pkg::PAMUX_IDLE;
            nxt_state.funcSel = `PAMUX_RST_FUNC_SEL;
            nxt_state.portOut = `PAMUX_RST_PORT_OUT;
            nxt_state.portDir = `PAMUX_RST_PORT_DIR;
            nxt_state.pinSample = 8'h00;
            nxt_state.pinDrv = 8'h00;
            nxt_state.pinOe = 8'h00;
            nxt_state.pready = 1'b0;
            nxt_state.pslverr = 1'b0;
            nxt_state.prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk) begin
        state_ff <= nxt_state;
    end

    // ==========================================================
    // outputs
    assign prdata = state_ff.prdata;
    assign pready = state_ff.pready;
    assign pslverr = state_ff.pslverr;
    assign firstPortBitOut = state_ff.pinDrv;
    assign firstPortBitOe = state_ff.pinOe;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_setup;
        psel && !penable && (state_ff.apbState == pamux_pkg::PAMUX_IDLE);
    endsequence

    sequence s_access;
        psel && penable && pready;
    endsequence

    a_apb_answer: assert property (s_setup |=> s_access or (pready && !penable))
        else $error("apb setup not answered in the next cycle");

    a_apb_ready_once: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");

    a_pin0_timer: assert property (
        $past(state_ff.funcSel[`PAMUX_BIT_TMR0]) |->
        firstPortBitOut[0] == $past(timer0Pulse) && firstPortBitOe[0])
        else $error("pin0 does not carry timer0 overflow");

    a_timer0_pulse_width: assert property (
        (state_ff.funcSel[`PAMUX_BIT_TMR0] && timer0Pulse) ##1
        state_ff.funcSel[`PAMUX_BIT_TMR0] |-> firstPortBitOut[0] ##1 !firstPortBitOut[0])
        else $error("timer0 overflow level not a single cycle");

    a_pin1_timer: assert property (
        $past(state_ff.funcSel[`PAMUX_BIT_TMR1]) |->
        firstPortBitOut[1] == $past(timer1Pulse) && firstPortBitOe[1])
        else $error("pin1 does not carry timer1 overflow");

    a_pin2_mem_oe: assert property (
        $past(state_ff.funcSel[`PAMUX_BIT_MEMOE]) |->
        firstPortBitOut[2] == $past(memOeN) && firstPortBitOe[2])
        else $error("pin2 does not carry memory output enable");

    a_pin3_mem_cs: assert property (
        $past(state_ff.funcSel[`PAMUX_BIT_MEMCS]) |->
        firstPortBitOut[3] == $past(memCsN) && firstPortBitOe[3])
        else $error("pin3 does not carry memory chip select");

    a_pin4_fifo_write: assert property (
        $past(state_ff.funcSel[`PAMUX_BIT_FIFOWR]) |->
        firstPortBitOut[4] == $past(fifoWriteStrobeN) && firstPortBitOe[4])
        else $error("pin4 does not carry fifo write strobe");

    a_pin5_fifo_read: assert property (
        $past(state_ff.funcSel[`PAMUX_BIT_FIFORD]) |->
        firstPortBitOut[5] == $past(fifoReadStrobeN) && firstPortBitOe[5])
        else $error("pin5 does not carry fifo read strobe");

    a_pin6_port_mode: assert property (
        !$past(state_ff.funcSel[`PAMUX_BIT_SER0]) |->
        firstPortBitOut[6] == $past(state_ff.portOut[6])
        && firstPortBitOe[6] == $past(state_ff.portDir[6]))
        else $error("pin6 not a port bit while deselected");

    a_ser0_idle_high: assert property (
        $past(state_ff.funcSel[`PAMUX_BIT_SER0]) |->
        firstPortBitOut[6] == ($past(serial0Mode) == `PAMUX_MODE_SYNC ?
        $past(serial0SyncDataOut) : 1'b1))
        else $error("pin6 serial0 value wrong for mode");

    a_pin7_port_mode: assert property (
        !$past(state_ff.funcSel[`PAMUX_BIT_SER1]) |->
        firstPortBitOut[7] == $past(state_ff.portOut[7])
        && firstPortBitOe[7] == $past(state_ff.portDir[7]))
        else $error("pin7 not a port bit while deselected");

    a_ser1_idle_high: assert property (
        $past(state_ff.funcSel[`PAMUX_BIT_SER1]) && $past(serial1Mode) != `PAMUX_MODE_SYNC
        |-> firstPortBitOut[7])
        else $error("pin7 not high outside sync mode");

    a_reset_port_mode: assert property (
        $past(rst) |-> state_ff.funcSel == 8'h00 ##1 firstPortBitOe == 8'h00)
        else $error("function selects not cleared by reset");

    a_timer1_pulse_width: assert property (
        (state_ff.funcSel[`PAMUX_BIT_TMR1] && timer1Pulse) ##1
        state_ff.funcSel[`PAMUX_BIT_TMR1] |-> firstPortBitOut[1] ##1 !firstPortBitOut[1])
        else $error("timer1 overflow level not a single cycle");

    a_apb_write_lands: assert property (
        (writeNow && hit == HIT_FUNC) |=> state_ff.funcSel == $past(pwdata[7:0]))
        else $error("function select write did not land");

    a_apb_unmapped_err: assert property (
        (psel && !penable && state_ff.apbState == pamux_pkg::PAMUX_IDLE && hit == 5'h00)
        |=> pready && pslverr)
        else $error("unmapped address answered without error");

    a_read_high_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("unused read data bits not zero");

    a_sel_pins_drive: assert property (
        (firstPortBitOe & $past(state_ff.funcSel)) == $past(state_ff.funcSel))
        else $error("selected pin not driven");

    // deselected low pins behave as plain port bits
    for (genvar i = 0; i < 6; i++) begin : g_port_bit
        a_port_bit_mode: assert property (
            !$past(state_ff.funcSel[i]) |->
            firstPortBitOut[i] == $past(state_ff.portOut[i])
            && firstPortBitOe[i] == $past(state_ff.portDir[i]))
            else $error("deselected pin not a port bit");
    end

endmodule

// [bench/pamux_pin_load.sv]
// pin loads and pull-ups on the far side of the eight port a pins
`timescale 1ns/1ps

module pamux_pin_load (
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] loadDrive,
    input wire logic [7:0] loadOe,
    output logic [7:0] pinIn
);
    // ==========================================
    // wire level per pin
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pinOe[i] && loadOe[i]) begin
                // both sides driving: contention
                pinIn[i] = 1'bx;
            end else if (pinOe[i]) begin
                pinIn[i] = pinOut[i];
            end else if (loadOe[i]) begin
                pinIn[i] = loadDrive[i];
            end else begin
                // released pins float up to the pull-up
                pinIn[i] = 1'b1;
            end
        end
    end
endmodule

// [bench/tb.sv]
// self-checking testbench of the port a function mux
`timescale 1ns/1ps
`include "pamux_cfg.svh"

module tb;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] timer0Mode, timer1Mode, serial0Mode, serial1Mode;
    logic timer0OvfFull, timer0OvfLow, timer1OvfFull, timer1OvfLow;
    logic memOeN, memCsN, fifoWriteStrobeN, fifoReadStrobeN;
    logic serial0SyncDataOut, serial1SyncDataOut;
    logic [7:0] pinIn, pinOut, pinOe, loadDrive, loadOe;
    int fails, checks;

    // ==========================================
    // design and pin loads
    pamux_port_a pamux_port_a_inst (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .timer0Mode(timer0Mode), .timer0OvfFull(timer0OvfFull),
        .timer0OvfLow(timer0OvfLow), .timer1Mode(timer1Mode),
        .timer1OvfFull(timer1OvfFull), .timer1OvfLow(timer1OvfLow),
        .memOeN(memOeN), .memCsN(memCsN), .fifoWriteStrobeN(fifoWriteStrobeN),
        .fifoReadStrobeN(fifoReadStrobeN), .serial0Mode(serial0Mode),
        .serial0SyncDataOut(serial0SyncDataOut), .serial1Mode(serial1Mode),
        .serial1SyncDataOut(serial1SyncDataOut), .firstPortBitIn(pinIn),
        .firstPortBitOut(pinOut), .firstPortBitOe(pinOe)
    );

    pamux_pin_load pamux_pin_load_inst (
        .pinOut(pinOut), .pinOe(pinOe), .loadDrive(loadDrive),
        .loadOe(loadOe), .pinIn(pinIn)
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ==========================================
    // shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, pready, 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, e});
    endtask

    task settle;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask

    // one overflow source raised and held; count pin high cycles
    task tmr(input int t, input logic [1:0] m, input logic low);
        int n;
        n = 0;
        @(posedge mclk);
        timer0Mode <= m;
        timer1Mode <= m;
        repeat (2) @(posedge mclk);
        if (t == 0) {timer0OvfFull, timer0OvfLow} <= {~low, low};
        else {timer1OvfFull, timer1OvfLow} <= {~low, low};
        repeat (8) begin
            @(negedge mclk);
            if (pinOut[t] !== 1'b0) n++;
        end
        @(posedge mclk);
        {timer0OvfFull, timer0OvfLow, timer1OvfFull, timer1OvfLow} <= 4'h0;
        repeat (3) @(posedge mclk);
        chk(32'(n), {31'h0, (m == `PAMUX_MODE_SPLIT) ? low : ~low});
    endtask

    task test_done;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        test_done();
    end

    // ==========================================
    // tests
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'h0, 12'h000, 32'h0};
        {timer0Mode, timer1Mode, serial0Mode, serial1Mode} = 8'h55;
        {timer0OvfFull, timer0OvfLow, timer1OvfFull, timer1OvfLow} = 4'h0;
        {memOeN, memCsN, fifoWriteStrobeN, fifoReadStrobeN} = 4'hF;
        {serial0SyncDataOut, serial1SyncDataOut} = 2'h0;
        {loadDrive, loadOe} = 16'h0000;
        fails = 0;
        checks = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk({24'h0, pinOe}, 32'h0000_0000);
        rdchk(`PAMUX_OFS_FUNC_SEL, 32'h0000_0000, 1'b0);
        rdchk(`PAMUX_OFS_PORT_OUT, 32'h0000_0000, 1'b0);
        rdchk(`PAMUX_OFS_PORT_DIR, 32'h0000_0000, 1'b0);
        rdchk(`PAMUX_OFS_PIN_DRIVE, 32'h0000_0000, 1'b0);
        // port bits: drive low nibble, loads on upper pins
        apb(1'b1, `PAMUX_OFS_PORT_OUT, 32'h0000_00A5);
        apb(1'b1, `PAMUX_OFS_PORT_DIR, 32'h0000_000F);
        @(posedge mclk);
        loadDrive <= 8'h3C;
        loadOe <= 8'hF0;
        settle();
        chk({pinOe, pinOut}, 32'h0000_0FA5);
        rdchk(`PAMUX_OFS_PIN_DRIVE, 32'h0000_0FA5, 1'b0);
        rdchk(`PAMUX_OFS_PORT_PIN, 32'h0000_0035, 1'b0);
        @(posedge mclk);
        loadOe <= 8'h00;
        settle();
        rdchk(`PAMUX_OFS_PORT_PIN, 32'h0000_00F5, 1'b0);
        rdchk(12'h014, 32'h0000_0000, 1'b1);
        apb(1'b1, `PAMUX_OFS_PORT_PIN, 32'h0000_00FF);
        chk({31'h0, err}, 32'h0000_0000);
        apb(1'b1, 12'h014, 32'h0000_00FF);
        chk({31'h0, err}, 32'h0000_0001);
        rdchk(`PAMUX_OFS_FUNC_SEL, 32'h0000_0000, 1'b0);
        // all alternate functions
        apb(1'b1, `PAMUX_OFS_FUNC_SEL, 32'h0000_00FF);
        rdchk(`PAMUX_OFS_FUNC_SEL, 32'h0000_00FF, 1'b0);
        settle();
        chk({24'h0, pinOe}, 32'h0000_00FF);
        for (int p = 0; p < 16; p++) begin
            @(posedge mclk);
            {fifoReadStrobeN, fifoWriteStrobeN, memCsN, memOeN} <= 4'(p);
            settle();
            chk({28'h0, pinOut[5:2]}, 32'(p));
        end
        for (int m = 0; m < 4; m++) begin
            for (int d = 0; d < 2; d++) begin
                @(posedge mclk);
                serial0Mode <= 2'(m);
                serial1Mode <= 2'(m);
                serial0SyncDataOut <= d[0];
                serial1SyncDataOut <= ~d[0];
                settle();
                chk({31'h0, pinOut[6]}, {31'h0, (m == 0) ? d[0] : 1'b1});
                chk({31'h0, pinOut[7]}, {31'h0, (m == 0) ? ~d[0] : 1'b1});
            end
        end
        for (int t = 0; t < 2; t++) begin
            for (int m = 0; m < 4; m++) begin
                tmr(t, 2'(m), 1'b0);
                tmr(t, 2'(m), 1'b1);
            end
        end
        // back to port bits
        apb(1'b1, `PAMUX_OFS_FUNC_SEL, 32'h0000_0000);
        settle();
        chk({pinOe, pinOut}, 32'h0000_0FA5);
        // reset in mid-run clears the selects
        apb(1'b1, `PAMUX_OFS_FUNC_SEL, 32'h0000_005A);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk({24'h0, pinOe}, 32'h0000_0000);
        rdchk(`PAMUX_OFS_FUNC_SEL, 32'h0000_0000, 1'b0);
        test_done();
    end
endmodule
